// *** rtl/uart_irq_dma.sv ***
// One UART channel: interrupt enables, FIFO status, interrupt source and DMA-ready pins
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_defs.svh"
// Summary of operation
// - Enable bit 3 lets the modem status interrupt through; off after reset.
// - Enable bit 2 lets the receive line status interrupt through; off after reset.
// - Enable bit 1 lets the transmitter-empty interrupt through; off after reset.
// - Enable bit 0 gives the receive interrupt at trigger level in FIFO mode.
// - Interrupt goes to a per-channel pin or a shared wire-OR request pin.
// - Trigger-level source shows in source register and clears below the level.
// - Data-ready sets when a character enters the receive FIFO, clears when empty.
// - FIFOs on with all enables clear gives polled operation through line status.
// - Line status bits 1 to 4 report overrun, parity, framing and break.
// - Line status bit 5 shows the transmit FIFO empty.
// - Line status bit 6 only when transmit FIFO and shifter are both empty.
// - Line status bit 7 shows an errored character somewhere in the receive FIFO.
// - DMA mode 0: transmit request low while the transmit FIFO or holding register is empty.
// - DMA mode 0: receive request low while a received character is held.
// - DMA mode 1: transmit interrupt set when any transmit FIFO location is free.
// - DMA mode 1: receive interrupt at trigger level; FIFO fills until full.
// - DMA mode 1: once low, receive request stays low while the FIFO holds any character.
// - FIFO control enables, clears, picks trigger level and DMA mode.
// - DMA mode 1: transmit request high when FIFO full, low otherwise.
// - DMA mode 1: receive request low on trigger or time-out until FIFO empty.
// - Trigger level comes from control bits 7:6; interrupt when count reaches it.
module uart_irq_dma
  import uart_irq_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clock, // 100 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic cs, // Chip select for this channel
  input wire logic [2:0] addr, // Register address
  input wire logic wr_stb, // One-cycle write strobe
  input wire logic rd_stb, // One-cycle read strobe
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata, // Read data, registered
  input wire logic bus_mode_68, // Shared wire-OR interrupt mode
  input wire logic rx_push, // Receiver delivers a character
  input wire logic [7:0] rx_char, // Received character
  input wire logic rx_par_err, // Parity error on that character
  input wire logic rx_frm_err, // Framing error on that character
  input wire logic rx_brk, // Break on that character
  input wire logic rx_timeout, // Receive time-out pulse
  input wire logic msr_change, // Modem status change pending
  input wire logic tx_pull, // Transmitter takes the head character
  input wire logic tx_shift_empty, // Transmit shifter idle
  output logic [7:0] tx_char, // Head of transmit FIFO
  output logic tx_avail, // Transmit FIFO holds a character
  output logic channel_irq, // Per-channel interrupt, active high
  output logic irq_n_out, // Shared request pin level when driven
  output logic irq_n_oe_n, // Shared request pin enable, low drives
  output logic tx_dma_request_n, // Transmit ready, active low
  output logic rx_dma_request_n // Receive ready, active low
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = CW'(`TRIG_L0);
      2'h1: trig_level = CW'(`TRIG_L1);
      2'h2: trig_level = CW'(`TRIG_L2);
      default: trig_level = CW'(`TRIG_L3);
    endcase
  endfunction : trig_level

  chan_state_t s_reg;
  chan_state_t s_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic gen_set;
  logic wr_thr, wr_ier, wr_fcr, wr_lcr, rd_rhr, rd_isr, rd_lsr;
  assign gen_set = cs && !s_reg.line_control_reg[`LCR_DIV_ACCESS];
  assign wr_thr = wr_stb && gen_set && addr == `OFS_DATA;
  assign wr_ier = wr_stb && gen_set && addr == `OFS_IER;
  assign wr_fcr = wr_stb && gen_set && addr == `OFS_FCR_ISR;
  assign wr_lcr = wr_stb && cs && addr == `OFS_LCR;
  assign rd_rhr = rd_stb && gen_set && addr == `OFS_DATA;
  assign rd_isr = rd_stb && gen_set && addr == `OFS_FCR_ISR;
  assign rd_lsr = rd_stb && cs && addr == `OFS_LSR;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic [CW-1:0] cap, rx_count, tx_count;
  logic rx_full, rx_empty, tx_full, tx_empty, rx_clr, tx_clr, en_change;
  logic [AW-1:0] rx_wptr, rx_rptr, tx_wptr, tx_rptr;
  logic [10:0] rx_head;
  logic rx_pop, rx_take, push_err, head_err;

  assign cap = s_reg.fifo_en ? CW'(DEPTH) : CW'(1);
  assign en_change = wdata[`FCR_FIFO_EN] != s_reg.fifo_en;
  assign rx_clr = wr_fcr && (wdata[`FCR_RX_CLR] || en_change);
  assign tx_clr = wr_fcr && (wdata[`FCR_TX_CLR] || en_change);
  assign rx_pop = rd_rhr && !rx_empty;
  assign rx_take = rx_push && !rx_full;
  assign push_err = rx_take && (rx_par_err || rx_frm_err || rx_brk);
  assign head_err = !rx_empty && |rx_head[10:8];

  fifo_ctrl #(.DEPTH(DEPTH), .AW(AW), .CW(CW)) rx_ptrs (
    .clock(clock), .rst_n(rst_sync_n), .clr(rx_clr), .push(rx_push), .pop(rx_pop),
    .cap(cap), .wptr(rx_wptr), .rptr_next(rx_rptr), .count(rx_count),
    .full(rx_full), .empty(rx_empty)
  );
  fifo_mem #(.W(11), .DEPTH(DEPTH), .AW(AW)) rx_store (
    .clock(clock), .we(rx_take), .waddr(rx_wptr),
    .wdata({rx_brk, rx_frm_err, rx_par_err, rx_char}), .raddr(rx_rptr), .rdata(rx_head)
  );
  fifo_ctrl #(.DEPTH(DEPTH), .AW(AW), .CW(CW)) tx_ptrs (
    .clock(clock), .rst_n(rst_sync_n), .clr(tx_clr), .push(wr_thr), .pop(tx_pull),
    .cap(cap), .wptr(tx_wptr), .rptr_next(tx_rptr), .count(tx_count),
    .full(tx_full), .empty(tx_empty)
  );
  fifo_mem #(.W(8), .DEPTH(DEPTH), .AW(AW)) tx_store (
    .clock(clock), .we(wr_thr && !tx_full), .waddr(tx_wptr),
    .wdata(wdata), .raddr(tx_rptr), .rdata(tx_char)
  );
  assign tx_avail = !tx_empty;

  // ----------------------------------------------------------------
  // Status and interrupt sources
  // ----------------------------------------------------------------
  logic mode1, lvl_hit, tx_space;
  logic rls_p, rdr_p, tmo_p, thr_p, msr_p, any_p;
  logic [7:0] line_status_reg;
  isr_src_t src;

  assign mode1 = s_reg.fifo_en && s_reg.dma_mode;
  assign lvl_hit = rx_count >= trig_level(s_reg.trig);
  assign tx_space = mode1 ? !tx_full : tx_empty;
  assign line_status_reg = {s_reg.fifo_en && s_reg.err_cnt != '0,
                tx_empty && tx_shift_empty,
                tx_empty,
                head_err && rx_head[10], head_err && rx_head[9],
                head_err && rx_head[8], s_reg.overrun,
                !rx_empty};
  assign rls_p = s_reg.interrupt_enable[`IER_LINE_STATUS] && (s_reg.overrun || head_err);
  assign rdr_p = s_reg.interrupt_enable[`IER_RX_READY] && (s_reg.fifo_en ? lvl_hit : !rx_empty);
  assign tmo_p = s_reg.interrupt_enable[`IER_RX_READY] && s_reg.timeout_pend;
  assign thr_p = s_reg.interrupt_enable[`IER_TX_EMPTY] && s_reg.thre_pend;
  assign msr_p = s_reg.interrupt_enable[`IER_MODEM] && msr_change;
  assign any_p = rls_p || rdr_p || tmo_p || thr_p || msr_p;

  always_comb begin
    if (rls_p) begin
      src = SRC_LINE;
    end else if (rdr_p) begin
      src = SRC_RX_DATA;
    end else if (tmo_p) begin
      src = SRC_TIMEOUT;
    end else if (thr_p) begin
      src = SRC_TX_EMPTY;
    end else if (msr_p) begin
      src = SRC_MODEM;
    end else begin
      src = SRC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (wr_ier) begin
      s_next.interrupt_enable = wdata[3:0];
    end
    if (wr_fcr) begin
      s_next.fifo_en = wdata[`FCR_FIFO_EN];
      s_next.dma_mode = wdata[`FCR_DMA_MODE];
      s_next.trig = wdata[`FCR_TRIG_LSB +: 2];
    end
    if (wr_lcr) begin
      s_next.line_control_reg = wdata;
    end
    if (wr_thr || (rd_isr && src == SRC_TX_EMPTY)) begin
      s_next.thre_pend = 1'b0;
    end
    if ((tx_space && !s_reg.tx_space_prev) || (wr_ier && wdata[`IER_TX_EMPTY] && tx_space)) begin
      s_next.thre_pend = 1'b1;
    end
    s_next.tx_space_prev = tx_space;
    if (rd_lsr) begin
      s_next.overrun = 1'b0;
    end
    if (rx_push && rx_full) begin
      s_next.overrun = 1'b1;
    end
    if (rd_rhr || rx_clr) begin
      s_next.timeout_pend = 1'b0;
    end
    if (rx_timeout && !rx_empty) begin
      s_next.timeout_pend = 1'b1;
    end
    s_next.rx_dma_act = mode1 && !rx_empty &&
                        (s_reg.rx_dma_act || lvl_hit || s_reg.timeout_pend);
    if (rx_clr) begin
      s_next.err_cnt = '0;
    end else begin
      s_next.err_cnt = s_reg.err_cnt + 5'(push_err) - 5'(rx_pop && |rx_head[10:8]);
    end
    s_next.irq = any_p;
    if (rd_stb && cs) begin
      case (addr)
        `OFS_DATA: s_next.rdata = gen_set ? rx_head[7:0] : 8'h00;
        `OFS_IER: s_next.rdata = gen_set ? {4'h0, s_reg.interrupt_enable} : 8'h00;
        `OFS_FCR_ISR: s_next.rdata = gen_set ? {{2{s_reg.fifo_en}}, 2'h0, src} : 8'h00;
        `OFS_LCR: s_next.rdata = s_reg.line_control_reg;
        `OFS_LSR: s_next.rdata = line_status_reg;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_reg <= '0;
      s_reg.interrupt_enable <= `IER_RESET;
      s_reg.line_control_reg <= `LCR_RESET;
      s_reg.trig <= `TRIG_RESET;
      s_reg.tx_space_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = s_reg.rdata;
  assign channel_irq = s_reg.irq && !bus_mode_68;
  assign irq_n_out = 1'b0;
  assign irq_n_oe_n = !(s_reg.irq && bus_mode_68);
  assign tx_dma_request_n = mode1 ? tx_full : !tx_empty;
  assign rx_dma_request_n = mode1 ? !s_reg.rx_dma_act : rx_empty;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  property p_modem_irq;
    s_reg.interrupt_enable[`IER_MODEM] && msr_change && !wr_ier && !bus_mode_68 |=>
      s_reg.irq && (channel_irq != bus_mode_68);
  endproperty
  a_modem_irq: assert property (p_modem_irq) else $error("modem irq missing");
  property p_line_irq;
    s_reg.interrupt_enable[`IER_LINE_STATUS] && s_reg.overrun && !wr_ier |=> s_reg.irq;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line irq missing");
  property p_trig_irq;
    s_reg.fifo_en && s_reg.interrupt_enable[`IER_RX_READY] && lvl_hit |=> s_reg.irq;
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("trigger irq missing");
  property p_single_irq;
    !s_reg.fifo_en && s_reg.interrupt_enable[`IER_RX_READY] && !rx_empty |=> s_reg.irq;
  endproperty
  a_single_irq: assert property (p_single_irq) else $error("rx irq missing");
  property p_quiet;
    s_reg.interrupt_enable == 4'h0 ##1 s_reg.interrupt_enable == 4'h0 |-> !s_reg.irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq with enables off");
  property p_ready;
    rx_take && !rx_clr |=> line_status_reg[0];
  endproperty
  a_ready: assert property (p_ready) else $error("data ready not set");
  property p_err_flag;
    push_err && !rx_clr && s_reg.fifo_en && !wr_fcr |=> line_status_reg[7];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("fifo error flag missing");
  property p_temt;
    line_status_reg[6] |-> line_status_reg[5] && tx_shift_empty;
  endproperty
  a_temt: assert property (p_temt) else $error("transmitter empty wrong");
  property p_tx_m0;
    !mode1 && tx_empty |-> !tx_dma_request_n;
  endproperty
  a_tx_m0: assert property (p_tx_m0) else $error("tx request mode 0");
  property p_tx_m1;
    mode1 |-> tx_dma_request_n == (tx_count >= CW'(DEPTH));
  endproperty
  a_tx_m1: assert property (p_tx_m1) else $error("tx request mode 1");
  property p_rx_hold;
    mode1 && !rx_dma_request_n && !wr_fcr && rx_count > 5'(1) |=> !rx_dma_request_n;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx request released early");
  property p_rx_trig;
    mode1 && lvl_hit && !wr_fcr |=> !rx_dma_request_n || rx_empty;
  endproperty
  a_rx_trig: assert property (p_rx_trig) else $error("rx request not at trigger");

  c_mode1_rx: cover property (mode1 && !rx_dma_request_n && rx_count > 5'(1));
  c_overrun: cover property (rx_push && rx_full);
  c_tmo_src: cover property (rd_isr && src == SRC_TIMEOUT);
endmodule : uart_irq_dma
`default_nettype wire

// *** rtl/uart_irq_defs.svh ***
// Register offsets, field positions, reset values and trigger levels of one UART channel
`ifndef UART_IRQ_DEFS_SVH
`define UART_IRQ_DEFS_SVH

`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_FCR_ISR 3'h2
`define OFS_LCR 3'h3
`define OFS_LSR 3'h5

`define IER_RX_READY 0
`define IER_TX_EMPTY 1
`define IER_LINE_STATUS 2
`define IER_MODEM 3
`define FCR_FIFO_EN 0
`define FCR_RX_CLR 1
`define FCR_TX_CLR 2
`define FCR_DMA_MODE 3
`define FCR_TRIG_LSB 6
`define LCR_DIV_ACCESS 7

`define IER_RESET 4'h0
`define LCR_RESET 8'h00
`define TRIG_RESET 2'h0

`define FIFO_DEPTH 16
`define TRIG_L0 8'h01
`define TRIG_L1 8'h04
`define TRIG_L2 8'h08
`define TRIG_L3 8'h0e

`endif

// *** rtl/uart_irq_pkg.sv ***
// Types shared by the channel interrupt and DMA-ready logic
package uart_irq_pkg;

  typedef enum logic [3:0] {
    SRC_MODEM = 4'b0000,
    SRC_NONE = 4'b0001,
    SRC_TX_EMPTY = 4'b0010,
    SRC_RX_DATA = 4'b0100,
    SRC_LINE = 4'b0110,
    SRC_TIMEOUT = 4'b1100
  } isr_src_t;

  typedef struct packed {
    logic [3:0] interrupt_enable;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] trig;
    logic [7:0] line_control_reg;
    logic overrun;
    logic thre_pend;
    logic tx_space_prev;
    logic timeout_pend;
    logic rx_dma_act;
    logic [4:0] err_cnt;
    logic irq;
    logic [7:0] rdata;
  } chan_state_t;

endpackage : uart_irq_pkg

// *** rtl/fifo_mem.sv ***
// Small FIFO storage with registered read data and write bypass
`timescale 1ns/10ps
`default_nettype none
module fifo_mem #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clock, // System clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [W-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address for next cycle
  output logic [W-1:0] rdata // Registered read data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : fifo_mem
`default_nettype wire

// *** rtl/fifo_ctrl.sv ***
// FIFO pointers and fill count with a run-time capacity
`timescale 1ns/10ps
`default_nettype none
module fifo_ctrl #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int CW = 5
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic clr, // Empty the FIFO
  input wire logic push, // Store one entry
  input wire logic pop, // Drop the head entry
  input wire logic [CW-1:0] cap, // Capacity in force
  output logic [AW-1:0] wptr, // Write pointer
  output logic [AW-1:0] rptr_next, // Head pointer for next cycle
  output logic [CW-1:0] count, // Fill level
  output logic full, // No room left
  output logic empty // Nothing held
);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
  } ptr_state_t;

  ptr_state_t s_reg;
  ptr_state_t s_next;
  logic do_push;
  logic do_pop;

  assign full = s_reg.count >= cap;
  assign empty = s_reg.count == '0;
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb begin
    s_next = s_reg;
    if (clr) begin
      s_next = '0;
    end else begin
      if (do_push) begin
        s_next.wptr = s_reg.wptr + 1'b1;
      end
      if (do_pop) begin
        s_next.rptr = s_reg.rptr + 1'b1;
      end
      s_next.count = s_reg.count + CW'(do_push) - CW'(do_pop);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wptr = s_reg.wptr;
  assign rptr_next = s_next.rptr;
  assign count = s_reg.count;
endmodule : fifo_ctrl
`default_nettype wire

// *** bench/host_model.sv ***
// Host CPU model that drives the channel register bus
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clock, // System clock
  output logic cs, // Channel select
  output logic [2:0] addr, // Register address
  output logic wr_stb, // Write strobe
  output logic rd_stb, // Read strobe
  output logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata // Read data
);
  logic div_on = 1'b0;
  int gap = 0;
  initial begin
    cs = 1'b0;
    addr = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  // ------------------------------------------
  // Bus cycles
  // ------------------------------------------
  // Released address and data show the inverse so stale values never match
  task xfer(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] r);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    cs <= 1'b1;
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= ~w;
    @(posedge clock);
    cs <= 1'b0;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
    r = rdata;
  endtask : xfer
  task wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic [7:0] v;
    v = d;
    if (a == 3'h1) v[7:4] = 4'h0;
    if (div_on && a < 3'h3) begin
      xfer(1'b1, 3'h3, 8'h00, r);
      div_on = 1'b0;
    end
    if (a == 3'h3) div_on = v[7];
    xfer(1'b1, a, v, r);
  endtask : wr
endmodule : host_model
`default_nettype wire

// *** bench/test_uart_irq_dma.sv ***
// Self-checking bench for the channel interrupt and DMA-ready logic
`timescale 1ns/10ps
`default_nettype none
module test_uart_irq_dma;
  logic clock, rst_n, cs, wr_stb, rd_stb, bus_mode_68, rx_push, rx_par_err;
  logic rx_frm_err, rx_brk, rx_timeout, msr_change, tx_pull, tx_shift_empty, tx_avail;
  logic channel_irq, irq_n_out, irq_n_oe_n, tx_dma_request_n, rx_dma_request_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rx_char, tx_char, q;
  int err_count = 0;
  int check_count = 0;
  typedef struct {logic [7:0] fifo_control_reg; int lvl;} trig_row_t;
  trig_row_t rows [4] = '{'{8'h03, 1}, '{8'h43, 4}, '{8'h83, 8}, '{8'hc3, 14}};

  uart_irq_dma u_uart_irq_dma (
    .clock, .rst_n, .cs, .addr, .wr_stb, .rd_stb, .wdata, .rdata, .bus_mode_68,
    .rx_push, .rx_char, .rx_par_err, .rx_frm_err, .rx_brk, .rx_timeout, .msr_change,
    .tx_pull, .tx_shift_empty, .tx_char, .tx_avail, .channel_irq, .irq_n_out,
    .irq_n_oe_n, .tx_dma_request_n, .rx_dma_request_n
  );
  host_model u_host_model (.clock, .cs, .addr, .wr_stb, .rd_stb, .wdata, .rdata);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task rc(input string n, input logic [2:0] a, input logic [7:0] e);
    u_host_model.xfer(1'b0, a, 8'h00, q);
    chk8(n, e, q);
  endtask : rc
  task push(input logic [7:0] c, input logic [2:0] err);
    @(posedge clock);
    rx_push <= 1'b1;
    rx_char <= c;
    {rx_brk, rx_frm_err, rx_par_err} <= err;
    @(posedge clock);
    rx_push <= 1'b0;
    rx_char <= ~c;
    #1;
  endtask : push
  task pull;
    @(posedge clock);
    tx_pull <= 1'b1;
    @(posedge clock);
    tx_pull <= 1'b0;
    #1;
  endtask : pull
  task finish_test;
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    finish_test;
  end
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    rst_n = 1'b0;
    {bus_mode_68, rx_push, rx_par_err, rx_frm_err, rx_brk, rx_timeout, msr_change} = '0;
    tx_pull = 1'b0;
    rx_char = 8'h00;
    tx_shift_empty = 1'b1;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    idle(4);
    chk1("txreq", 1'b0, tx_dma_request_n);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    chk1("oe", 1'b1, irq_n_oe_n);
    rc("ier", 3'h1, 8'h00);
    rc("lsr", 3'h5, 8'h60);
    // Single character with FIFOs off
    u_host_model.wr(3'h1, 8'h01);
    push(8'h5a, 3'h0);
    chk1("rxreq", 1'b0, rx_dma_request_n);
    idle(2);
    chk1("irq", 1'b1, channel_irq);
    rc("lsr", 3'h5, 8'h61);
    rc("rhr", 3'h0, 8'h5a);
    idle(2);
    chk1("irq", 1'b0, channel_irq);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    rc("lsr", 3'h5, 8'h60);
    // Overrun and line status masking
    u_host_model.wr(3'h1, 8'h00);
    push(8'h11, 3'h0);
    push(8'h22, 3'h0);
    idle(2);
    chk1("irq", 1'b0, channel_irq);
    u_host_model.wr(3'h1, 8'h04);
    idle(2);
    chk1("irq", 1'b1, channel_irq);
    rc("isr line", 3'h2, 8'h06);
    rc("lsr", 3'h5, 8'h63);
    idle(2);
    chk1("irq", 1'b0, channel_irq);
    rc("lsr", 3'h5, 8'h61);
    rc("rhr", 3'h0, 8'h11);
    // Modem source and shared request pin
    u_host_model.wr(3'h1, 8'h00);
    @(posedge clock);
    msr_change <= 1'b1;
    idle(2);
    chk1("irq", 1'b0, channel_irq);
    u_host_model.wr(3'h1, 8'h08);
    idle(2);
    chk1("irq", 1'b1, channel_irq);
    rc("isr modem", 3'h2, 8'h00);
    @(posedge clock);
    bus_mode_68 <= 1'b1;
    idle(1);
    chk1("irq68", 1'b0, channel_irq);
    chk1("oe68", 1'b0, irq_n_oe_n);
    chk1("pin68", 1'b0, irq_n_out);
    @(posedge clock);
    bus_mode_68 <= 1'b0;
    msr_change <= 1'b0;
    idle(3);
    chk1("irq", 1'b0, channel_irq);
    // Receive trigger levels
    u_host_model.wr(3'h1, 8'h01);
    foreach (rows[i]) begin
      u_host_model.wr(3'h2, rows[i].fifo_control_reg);
      repeat (rows[i].lvl - 1) push(8'h00, 3'h0);
      idle(2);
      chk1("irq low", 1'b0, channel_irq);
      rc("isr low", 3'h2, 8'hc1);
      push(8'h00, 3'h0);
      idle(2);
      chk1("irq trig", 1'b1, channel_irq);
      rc("isr trig", 3'h2, 8'hc4);
      rc("rhr", 3'h0, 8'h00);
      idle(2);
      chk1("irq drop", 1'b0, channel_irq);
      rc("isr drop", 3'h2, 8'hc1);
    end
    // Polled mode and error flags
    u_host_model.wr(3'h1, 8'h00);
    u_host_model.wr(3'h2, 8'h03);
    push(8'h41, 3'h0);
    push(8'h42, 3'b001);
    push(8'h43, 3'b110);
    idle(2);
    chk1("irq poll", 1'b0, channel_irq);
    rc("lsr", 3'h5, 8'he1);
    rc("rhr", 3'h0, 8'h41);
    rc("lsr", 3'h5, 8'he5);
    rc("rhr", 3'h0, 8'h42);
    rc("lsr", 3'h5, 8'hf9);
    rc("rhr", 3'h0, 8'h43);
    rc("lsr", 3'h5, 8'h60);
    // Transmit side in mode 1
    u_host_model.wr(3'h2, 8'h0f);
    u_host_model.wr(3'h1, 8'h02);
    idle(2);
    chk1("irq tx", 1'b1, channel_irq);
    rc("isr tx", 3'h2, 8'hc2);
    idle(2);
    chk1("irq isr", 1'b0, channel_irq);
    for (int i = 0; i < 15; i++) u_host_model.wr(3'h0, 8'(i));
    chk1("txreq", 1'b0, tx_dma_request_n);
    u_host_model.wr(3'h0, 8'h0f);
    u_host_model.wr(3'h0, 8'hff);
    idle(2);
    chk1("txreq full", 1'b1, tx_dma_request_n);
    chk1("irq full", 1'b0, channel_irq);
    rc("lsr full", 3'h5, 8'h00);
    for (int i = 0; i < 16; i++) begin
      idle(1);
      chk8("tx_char", 8'(i), tx_char);
      pull;
      if (i == 0) begin
        chk1("txreq", 1'b0, tx_dma_request_n);
        idle(3);
        chk1("irq tx", 1'b1, channel_irq);
      end
    end
    idle(1);
    chk1("tx_avail", 1'b0, tx_avail);
    rc("lsr", 3'h5, 8'h60);
    @(posedge clock);
    tx_shift_empty <= 1'b0;
    rc("lsr busy", 3'h5, 8'h20);
    @(posedge clock);
    tx_shift_empty <= 1'b1;
    // Transmit side in mode 0
    u_host_model.wr(3'h2, 8'h01);
    chk1("txreq", 1'b0, tx_dma_request_n);
    u_host_model.wr(3'h0, 8'h33);
    chk1("txreq", 1'b1, tx_dma_request_n);
    pull;
    idle(1);
    chk1("txreq", 1'b0, tx_dma_request_n);
    // Receive side in mode 1, trigger 4
    u_host_model.wr(3'h1, 8'h01);
    u_host_model.wr(3'h2, 8'h4b);
    for (int i = 0; i < 3; i++) push(8'(i), 3'h0);
    idle(1);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    for (int i = 3; i < 17; i++) push(8'(i), 3'h0);
    idle(2);
    chk1("rxreq", 1'b0, rx_dma_request_n);
    chk1("irq", 1'b1, channel_irq);
    rc("lsr", 3'h5, 8'h63);
    for (int i = 0; i < 16; i++) begin
      rc("rhr", 3'h0, 8'(i));
      if (i == 12) chk1("rxreq", 1'b0, rx_dma_request_n);
    end
    idle(1);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    push(8'h77, 3'h0);
    idle(1);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    @(posedge clock);
    rx_timeout <= 1'b1;
    @(posedge clock);
    rx_timeout <= 1'b0;
    idle(2);
    chk1("rxreq", 1'b0, rx_dma_request_n);
    rc("isr", 3'h2, 8'hcc);
    rc("rhr", 3'h0, 8'h77);
    idle(1);
    chk1("rxreq", 1'b1, rx_dma_request_n);
    // Divisor access, IER write with reserved bits cleared by the host, unmapped place, slow host
    u_host_model.gap = 2;
    u_host_model.wr(3'h1, 8'hf5);
    rc("ier", 3'h1, 8'h05);
    u_host_model.wr(3'h3, 8'h80);
    u_host_model.xfer(1'b1, 3'h1, 8'h0f, q);
    rc("ier div", 3'h1, 8'h00);
    u_host_model.wr(3'h3, 8'h00);
    rc("ier", 3'h1, 8'h05);
    rc("unmapped", 3'h7, 8'h00);
    u_host_model.gap = 0;
    // Second reset in mid-run
    @(posedge clock);
    rst_n <= 1'b0;
    idle(2);
    chk1("oe rst", 1'b1, irq_n_oe_n);
    @(posedge clock);
    rst_n <= 1'b1;
    idle(4);
    rc("ier", 3'h1, 8'h00);
    rc("lsr", 3'h5, 8'h60);
    finish_test;
  end
endmodule : test_uart_irq_dma
`default_nettype wire
